// File: pbpf_defs.vh
`ifndef PBPF_DEFS_VH
`define PBPF_DEFS_VH

// register bus
`define PBPF_ADDR_W 32
`define PBPF_DATA_W 16
`define PBPF_OFS_SEL_HIGH 32'h05ff_ffcc
`define PBPF_OFS_SEL_LOW 32'h05ff_ffce
`define PBPF_SEL_HIGH_RST 16'h0000
`define PBPF_SEL_LOW_RST 16'h0000
`define PBPF_RD_IDLE 16'h0000

// mode field layout
`define PBPF_FLD_W 2
`define PBPF_PIN15_POS 14
`define PBPF_PIN14_POS 12
`define PBPF_PIN13_POS 10
`define PBPF_PIN12_POS 8
`define PBPF_PIN11_POS 6
`define PBPF_PIN10_POS 4
`define PBPF_PIN9_POS 2
`define PBPF_PIN8_POS 0
`define PBPF_PIN7_POS 14
`define PBPF_PIN6_POS 12
`define PBPF_PIN5_POS 10
`define PBPF_PIN4_POS 8
`define PBPF_PIN3_POS 6
`define PBPF_PIN2_POS 4
`define PBPF_PIN1_POS 2
`define PBPF_PIN0_POS 0

// mode codes
`define PBPF_MD_GPIO 2'b00
`define PBPF_MD_ALT1 2'b01
`define PBPF_MD_ALT2 2'b10
`define PBPF_MD_TP 2'b11

// level seen by a peripheral whose pin is routed elsewhere, and the synchroniser reset level
`define PBPF_IRQ_IDLE 1'b1
`define PBPF_RXD_IDLE 1'b1
`define PBPF_SCK_IDLE 1'b1
`define PBPF_TCLK_IDLE 1'b0
`define PBPF_TIO_IDLE 1'b0
`define PBPF_SYNC_RST 1'b0

`endif

// File: pbpf_periph_model.sv
`timescale 1ns/10ps
module pbpf_periph_model
(
   input wire [15:0] pin_out,
   input wire [15:0] pin_oe,
   input wire [15:0] ext_val,
   input wire [15:0] ext_en,
   output wire [15:0] pin_in
);
// board pull-ups hold a released pad high; contention is not modelled
assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule

// File: pbpf_pin_mux.v
// Contract
// - pin 15: gpio, interrupt 7, reserved, pattern bit 15 from high field 15:14
// - pin 14: gpio, interrupt 6, reserved, pattern bit 14 from high field 13:12
// - pin 13: gpio, interrupt 5, serial 1 clock, pattern bit 13
// - pin 12: gpio, interrupt 4, serial 0 clock, pattern bit 12
// - pin 11: gpio, reserved, serial 1 transmit, pattern bit 11
// - pin 10: gpio, reserved, serial 1 receive, pattern bit 10
// - pin 9: gpio, reserved, serial 0 transmit, pattern bit 9
// - pin 8: gpio, reserved, serial 0 receive, pattern bit 8
// - pin 7: gpio, timer clock d, timer 4 compare b, pattern bit 7
// - pin 6: gpio, timer clock c, timer 4 compare a, pattern bit 6
// - pin 5: gpio, reserved, timer 4 capture/compare b, pattern bit 5
// - pin 4: gpio, reserved, timer 4 capture/compare a, pattern bit 4
// - pin 3: gpio, reserved, timer 3 capture/compare b, pattern bit 3
// - pin 2: gpio, reserved, timer 3 capture/compare a, pattern bit 2
// - pin 1: gpio, reserved, timer 2 capture/compare b, pattern bit 1
// - pin 0: gpio, reserved, timer 2 capture/compare a, pattern bit 0
// - all fields reset to zero, so every pin starts as gpio; all readable and writable
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "pbpf_defs.vh"

module pbpf_pin_mux
(
   input wire mclk,
   input wire rst,
   input wire [`PBPF_ADDR_W-1:0] bus_addr,
   input wire [`PBPF_DATA_W-1:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   output wire [`PBPF_DATA_W-1:0] bus_rdata,
   input wire [15:0] pin_in,
   output reg [15:0] pin_out,
   output reg [15:0] pin_oe,
   input wire [15:0] gpio_out,
   input wire [15:0] gpio_oe,
   output wire [15:0] gpio_in,
   input wire [15:0] timing_pattern,
   output wire ext_interrupt_7,
   output wire ext_interrupt_6,
   output wire ext_interrupt_5,
   output wire ext_interrupt_4,
   input wire serial1_clock_out,
   input wire serial1_clock_oe,
   output wire serial1_clock_in,
   input wire serial0_clock_out,
   input wire serial0_clock_oe,
   output wire serial0_clock_in,
   input wire serial1_transmit,
   input wire serial0_transmit,
   output wire serial1_receive,
   output wire serial0_receive,
   output wire timer_ext_clock_d,
   output wire timer_ext_clock_c,
   input wire timer4_compare_out_b,
   input wire timer4_compare_out_a,
   input wire timer4_capcomp_b_out,
   input wire timer4_capcomp_b_oe,
   output wire timer4_capcomp_b_in,
   input wire timer4_capcomp_a_out,
   input wire timer4_capcomp_a_oe,
   output wire timer4_capcomp_a_in,
   input wire timer3_capcomp_b_out,
   input wire timer3_capcomp_b_oe,
   output wire timer3_capcomp_b_in,
   input wire timer3_capcomp_a_out,
   input wire timer3_capcomp_a_oe,
   output wire timer3_capcomp_a_in,
   input wire timer2_capcomp_b_out,
   input wire timer2_capcomp_b_oe,
   output wire timer2_capcomp_b_in,
   input wire timer2_capcomp_a_out,
   input wire timer2_capcomp_a_oe,
   output wire timer2_capcomp_a_in
);

////////////////////////////////////////////////////////////////////////////////
// storage

reg [`PBPF_DATA_W-1:0] sel_high_r;
reg [`PBPF_DATA_W-1:0] sel_low_r;
reg [`PBPF_DATA_W-1:0] rdata_r;
wire [15:0] pin_s;
wire hit_high;
wire hit_low;
integer i;

assign hit_high = (bus_addr == `PBPF_OFS_SEL_HIGH);
assign hit_low = (bus_addr == `PBPF_OFS_SEL_LOW);

////////////////////////////////////////////////////////////////////////////////
// pin input synchronisers
// every pin is synchronised, even in output modes, so gpio reads see the pad

genvar gi;
generate
   for (gi = 0; gi < 16; gi = gi + 1)
   begin : g_sync
      pbpf_sync3 u_sync
      (
         .mclk(mclk),
         .rst(rst),
         .async_in(pin_in[gi]),
         .sync_out(pin_s[gi])
      );
   end
endgenerate

assign gpio_in = pin_s;

////////////////////////////////////////////////////////////////////////////////
// register writes

always @(posedge mclk or posedge rst)
begin
   if (rst)
   begin
      sel_high_r <= `PBPF_SEL_HIGH_RST;
      sel_low_r <= `PBPF_SEL_LOW_RST;
   end
   else if (bus_wr)
   begin
      if (hit_high)
      begin
         sel_high_r <= bus_wdata;
      end
      else if (hit_low)
      begin
         sel_low_r <= bus_wdata;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// register reads: data stand only in the cycle after the strobe

always @(posedge mclk or posedge rst)
begin
   if (rst)
   begin
      rdata_r <= `PBPF_RD_IDLE;
   end
   else if (bus_rd)
   begin
      if (hit_high)
      begin
         rdata_r <= sel_high_r;
      end
      else if (hit_low)
      begin
         rdata_r <= sel_low_r;
      end
      else
      begin
         rdata_r <= `PBPF_RD_IDLE;
      end
   end
   else
   begin
      rdata_r <= `PBPF_RD_IDLE;
   end
end

assign bus_rdata = rdata_r;

////////////////////////////////////////////////////////////////////////////////
// per-pin mode fields

wire [1:0] md15 = sel_high_r[`PBPF_PIN15_POS +: `PBPF_FLD_W];
wire [1:0] md14 = sel_high_r[`PBPF_PIN14_POS +: `PBPF_FLD_W];
wire [1:0] md13 = sel_high_r[`PBPF_PIN13_POS +: `PBPF_FLD_W];
wire [1:0] md12 = sel_high_r[`PBPF_PIN12_POS +: `PBPF_FLD_W];
wire [1:0] md11 = sel_high_r[`PBPF_PIN11_POS +: `PBPF_FLD_W];
wire [1:0] md10 = sel_high_r[`PBPF_PIN10_POS +: `PBPF_FLD_W];
wire [1:0] md9 = sel_high_r[`PBPF_PIN9_POS +: `PBPF_FLD_W];
wire [1:0] md8 = sel_high_r[`PBPF_PIN8_POS +: `PBPF_FLD_W];
wire [1:0] md7 = sel_low_r[`PBPF_PIN7_POS +: `PBPF_FLD_W];
wire [1:0] md6 = sel_low_r[`PBPF_PIN6_POS +: `PBPF_FLD_W];
wire [1:0] md5 = sel_low_r[`PBPF_PIN5_POS +: `PBPF_FLD_W];
wire [1:0] md4 = sel_low_r[`PBPF_PIN4_POS +: `PBPF_FLD_W];
wire [1:0] md3 = sel_low_r[`PBPF_PIN3_POS +: `PBPF_FLD_W];
wire [1:0] md2 = sel_low_r[`PBPF_PIN2_POS +: `PBPF_FLD_W];
wire [1:0] md1 = sel_low_r[`PBPF_PIN1_POS +: `PBPF_FLD_W];
wire [1:0] md0 = sel_low_r[`PBPF_PIN0_POS +: `PBPF_FLD_W];

wire [31:0] md_all = {md15, md14, md13, md12, md11, md10, md9, md8,
                      md7, md6, md5, md4, md3, md2, md1, md0};

////////////////////////////////////////////////////////////////////////////////
// pad drive
// combinational from the mode flops, so a write acts on the very next cycle;
// the peripherals' own outputs are assumed to be flops on mclk

always @*
begin
   pin_out = 16'h0000;
   pin_oe = 16'h0000;
   for (i = 0; i < 16; i = i + 1)
   begin
      if (md_all[2*i +: 2] == `PBPF_MD_GPIO)
      begin
         pin_out[i] = gpio_out[i];
         pin_oe[i] = gpio_oe[i];
      end
      else if (md_all[2*i +: 2] == `PBPF_MD_TP)
      begin
         pin_out[i] = timing_pattern[i];
         pin_oe[i] = 1'b1;
      end
   end
   // reserved codes and input-only functions fall through with the pad released
   if (md13 == `PBPF_MD_ALT2)
   begin
      pin_out[13] = serial1_clock_out;
      pin_oe[13] = serial1_clock_oe;
   end
   if (md12 == `PBPF_MD_ALT2)
   begin
      pin_out[12] = serial0_clock_out;
      pin_oe[12] = serial0_clock_oe;
   end
   if (md11 == `PBPF_MD_ALT2)
   begin
      pin_out[11] = serial1_transmit;
      pin_oe[11] = 1'b1;
   end
   if (md9 == `PBPF_MD_ALT2)
   begin
      pin_out[9] = serial0_transmit;
      pin_oe[9] = 1'b1;
   end
   if (md7 == `PBPF_MD_ALT2)
   begin
      pin_out[7] = timer4_compare_out_b;
      pin_oe[7] = 1'b1;
   end
   if (md6 == `PBPF_MD_ALT2)
   begin
      pin_out[6] = timer4_compare_out_a;
      pin_oe[6] = 1'b1;
   end
   if (md5 == `PBPF_MD_ALT2)
   begin
      pin_out[5] = timer4_capcomp_b_out;
      pin_oe[5] = timer4_capcomp_b_oe;
   end
   if (md4 == `PBPF_MD_ALT2)
   begin
      pin_out[4] = timer4_capcomp_a_out;
      pin_oe[4] = timer4_capcomp_a_oe;
   end
   if (md3 == `PBPF_MD_ALT2)
   begin
      pin_out[3] = timer3_capcomp_b_out;
      pin_oe[3] = timer3_capcomp_b_oe;
   end
   if (md2 == `PBPF_MD_ALT2)
   begin
      pin_out[2] = timer3_capcomp_a_out;
      pin_oe[2] = timer3_capcomp_a_oe;
   end
   if (md1 == `PBPF_MD_ALT2)
   begin
      pin_out[1] = timer2_capcomp_b_out;
      pin_oe[1] = timer2_capcomp_b_oe;
   end
   if (md0 == `PBPF_MD_ALT2)
   begin
      pin_out[0] = timer2_capcomp_a_out;
      pin_oe[0] = timer2_capcomp_a_oe;
   end
end

////////////////////////////////////////////////////////////////////////////////
// peripheral inputs
// a deselected peripheral sees its idle level, never the pad, so a pin used
// for gpio cannot raise a stray interrupt or clock a timer

// external interrupts, idle high so no request is seen
assign ext_interrupt_7 = (md15 == `PBPF_MD_ALT1) ? pin_s[15] : `PBPF_IRQ_IDLE;
assign ext_interrupt_6 = (md14 == `PBPF_MD_ALT1) ? pin_s[14] : `PBPF_IRQ_IDLE;
assign ext_interrupt_5 = (md13 == `PBPF_MD_ALT1) ? pin_s[13] : `PBPF_IRQ_IDLE;
assign ext_interrupt_4 = (md12 == `PBPF_MD_ALT1) ? pin_s[12] : `PBPF_IRQ_IDLE;

// serial clocks and receive data; lines idle at mark
assign serial1_clock_in = (md13 == `PBPF_MD_ALT2) ? pin_s[13] : `PBPF_SCK_IDLE;
assign serial0_clock_in = (md12 == `PBPF_MD_ALT2) ? pin_s[12] : `PBPF_SCK_IDLE;
assign serial1_receive = (md10 == `PBPF_MD_ALT2) ? pin_s[10] : `PBPF_RXD_IDLE;
assign serial0_receive = (md8 == `PBPF_MD_ALT2) ? pin_s[8] : `PBPF_RXD_IDLE;

// timer external clocks
assign timer_ext_clock_d = (md7 == `PBPF_MD_ALT1) ? pin_s[7] : `PBPF_TCLK_IDLE;
assign timer_ext_clock_c = (md6 == `PBPF_MD_ALT1) ? pin_s[6] : `PBPF_TCLK_IDLE;

// timer capture inputs; the pad value returns even while the timer drives it
assign timer4_capcomp_b_in = (md5 == `PBPF_MD_ALT2) ? pin_s[5] : `PBPF_TIO_IDLE;
assign timer4_capcomp_a_in = (md4 == `PBPF_MD_ALT2) ? pin_s[4] : `PBPF_TIO_IDLE;
assign timer3_capcomp_b_in = (md3 == `PBPF_MD_ALT2) ? pin_s[3] : `PBPF_TIO_IDLE;
assign timer3_capcomp_a_in = (md2 == `PBPF_MD_ALT2) ? pin_s[2] : `PBPF_TIO_IDLE;
assign timer2_capcomp_b_in = (md1 == `PBPF_MD_ALT2) ? pin_s[1] : `PBPF_TIO_IDLE;
assign timer2_capcomp_a_in = (md0 == `PBPF_MD_ALT2) ? pin_s[0] : `PBPF_TIO_IDLE;

endmodule

// File: pbpf_pin_mux_bench.sv
`timescale 1ns/10ps
`include "pbpf_defs.vh"
module pbpf_pin_mux_bench;
logic mclk, rst, bus_wr, bus_rd;
logic [31:0] bus_addr;
logic [15:0] bus_wdata, gpio_out, gpio_oe, timing_pattern, ext_val, ext_en;
logic serial1_clock_out, serial1_clock_oe, serial0_clock_out, serial0_clock_oe;
logic serial1_transmit, serial0_transmit, timer4_compare_out_b, timer4_compare_out_a;
logic timer4_capcomp_b_out, timer4_capcomp_b_oe, timer4_capcomp_a_out, timer4_capcomp_a_oe;
logic timer3_capcomp_b_out, timer3_capcomp_b_oe, timer3_capcomp_a_out, timer3_capcomp_a_oe;
logic timer2_capcomp_b_out, timer2_capcomp_b_oe, timer2_capcomp_a_out, timer2_capcomp_a_oe;
wire [15:0] bus_rdata, pin_in, pin_out, pin_oe, gpio_in;
wire ext_interrupt_7, ext_interrupt_6, ext_interrupt_5, ext_interrupt_4;
wire serial1_clock_in, serial0_clock_in, serial1_receive, serial0_receive;
wire timer_ext_clock_d, timer_ext_clock_c, timer4_capcomp_b_in, timer4_capcomp_a_in;
wire timer3_capcomp_b_in, timer3_capcomp_a_in, timer2_capcomp_b_in, timer2_capcomp_a_in;
wire [15:0] per_in = {ext_interrupt_7, ext_interrupt_6, ext_interrupt_5, ext_interrupt_4,
   serial1_clock_in, serial0_clock_in, serial1_receive, serial0_receive,
   timer_ext_clock_d, timer_ext_clock_c, timer4_capcomp_b_in, timer4_capcomp_a_in,
   timer3_capcomp_b_in, timer3_capcomp_a_in, timer2_capcomp_b_in, timer2_capcomp_a_in};
int err_total = 0;
int num_checks = 0;
int cyc = 0;
pbpf_pin_mux u_pbpf_pin_mux (.*);
pbpf_periph_model u_pbpf_periph_model (.*);
always #10 mclk = ~mclk;
////////////////////////////////////////
task chk(input string what, input [15:0] exp, input [15:0] got);
   num_checks++;
   if (got !== exp)
   begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
   end
endtask
task wr(input [31:0] a, input [15:0] d);
   @(posedge mclk);
   bus_wr <= 1'b1;
   bus_addr <= a;
   bus_wdata <= d;
   @(posedge mclk);
   bus_wr <= 1'b0;
   #1;
endtask
task rd(input [31:0] a, input [15:0] exp);
   @(posedge mclk);
   bus_rd <= 1'b1;
   bus_addr <= a;
   @(posedge mclk);
   bus_rd <= 1'b0;
   #1 chk("read data", exp, bus_rdata);
endtask
// pads pass four flops (s1_r, s2_r, s3_r, sync_out), so six edges cover the synchroniser
task setup(input [15:0] hi, input [15:0] lo, input [19:0] src, input [15:0] en, input [15:0] v);
   wr(`PBPF_OFS_SEL_HIGH, hi);
   wr(`PBPF_OFS_SEL_LOW, lo);
   @(posedge mclk);
   {serial1_clock_out, serial1_clock_oe, serial0_clock_out, serial0_clock_oe,
      serial1_transmit, serial0_transmit, timer4_compare_out_b, timer4_compare_out_a,
      timer4_capcomp_b_out, timer4_capcomp_b_oe, timer4_capcomp_a_out, timer4_capcomp_a_oe,
      timer3_capcomp_b_out, timer3_capcomp_b_oe, timer3_capcomp_a_out, timer3_capcomp_a_oe,
      timer2_capcomp_b_out, timer2_capcomp_b_oe, timer2_capcomp_a_out, timer2_capcomp_a_oe} <= src;
   ext_en <= en;
   ext_val <= v;
   repeat (6) @(posedge mclk);
   #1;
endtask
task finish_test;
   $display("checks %0d mismatches %0d", num_checks, err_total);
   if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
   else
      $display("Finished with errors");
   $finish;
endtask
////////////////////////////////////////
task t_gpio;
   gpio_oe <= 16'h00ff;
   gpio_out <= 16'h1234;
   setup(16'h0000, 16'h0000, 20'h0_0000, 16'hff00, 16'ha500);
   rd(`PBPF_OFS_SEL_HIGH, 16'h0000);
   rd(`PBPF_OFS_SEL_LOW, 16'h0000);
   chk("pad enable", 16'h00ff, pin_oe);
   chk("pad value", 16'h0034, pin_out & pin_oe);
   chk("gpio input", 16'ha534, gpio_in);
   chk("peripheral inputs", 16'hff00, per_in);
   $display("test gpio done");
endtask
task t_regs;
   wr(`PBPF_OFS_SEL_HIGH, 16'h1e2d);
   wr(`PBPF_OFS_SEL_LOW, 16'hc3b4);
   wr(32'h05ff_ffd0, 16'hffff);
   rd(`PBPF_OFS_SEL_HIGH, 16'h1e2d);
   rd(`PBPF_OFS_SEL_LOW, 16'hc3b4);
   rd(32'h05ff_ffd0, 16'h0000);
   $display("test regs done");
endtask
task t_alt;
   setup(16'haaaa, 16'haaaa, 20'ha_faaa, 16'h353f, 16'h0100);
   chk("pad enable", 16'h0ac0, pin_oe);
   chk("pad value", 16'h0ac0, pin_out & pin_oe);
   chk("peripheral inputs", 16'hf100, per_in);
   setup(16'haaaa, 16'haaaa, 20'hf_ffff, 16'h353f, 16'h0100);
   chk("pad enable", 16'h3aff, pin_oe);
   chk("pad value", 16'h3aff, pin_out & pin_oe);
   chk("peripheral inputs", 16'hfd3f, per_in);
   setup(16'h5555, 16'h5555, 20'h0_0000, 16'hffff, 16'h3080);
   chk("pad enable", 16'h0000, pin_oe);
   chk("peripheral inputs", 16'h3f80, per_in);
   chk("gpio input", 16'h3080, gpio_in);
   $display("test alternate done");
endtask
task t_tp;
   @(posedge mclk);
   timing_pattern <= 16'h5a3c;
   setup(16'hffff, 16'hffff, 20'h0_0000, 16'h0000, 16'h0000);
   chk("pad enable", 16'hffff, pin_oe);
   chk("pad value", 16'h5a3c, pin_out);
   @(posedge mclk);
   timing_pattern <= 16'ha5c3;
   @(posedge mclk);
   #1 chk("pad value", 16'ha5c3, pin_out);
   @(posedge mclk);
   rst <= 1'b1;
   repeat (3) @(posedge mclk);
   rst <= 1'b0;
   rd(`PBPF_OFS_SEL_LOW, 16'h0000);
   rd(`PBPF_OFS_SEL_HIGH, 16'h0000);
   // after reset every pin is gpio again, so the pads follow the port direction
   chk("pad enable", 16'h00ff, pin_oe);
   chk("peripheral inputs", 16'hff00, per_in);
   $display("test pattern done");
endtask
////////////////////////////////////////
always @(posedge mclk)
begin
   cyc++;
   if (cyc == 2000)
   begin
      err_total++;
      finish_test;
   end
end
initial
begin
   mclk = 1'b0;
   rst = 1'b1;
   {bus_wr, bus_rd, bus_addr, bus_wdata, gpio_out, gpio_oe, timing_pattern, ext_val, ext_en} = '0;
   repeat (3) @(posedge mclk);
   rst <= 1'b0;
   t_gpio;
   t_regs;
   t_alt;
   t_tp;
   finish_test;
end
endmodule

// File: pbpf_pin_mux_properties.sv
`timescale 1ns/10ps
`include "pbpf_defs.vh"
module pbpf_pin_mux_properties
(
   input wire mclk,
   input wire rst,
   input wire [`PBPF_ADDR_W-1:0] bus_addr,
   input wire [`PBPF_DATA_W-1:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   input wire [`PBPF_DATA_W-1:0] bus_rdata,
   input wire [15:0] pin_out,
   input wire [15:0] pin_oe,
   input wire [15:0] gpio_out,
   input wire [15:0] gpio_oe,
   input wire [15:0] timing_pattern,
   input wire ext_interrupt_7,
   input wire serial1_transmit,
   input wire timer4_compare_out_b
);
reg [15:0] hi_r;
reg [15:0] lo_r;
// shadow copies of the selects, so routing is judged without peeking inside
always @(posedge mclk or posedge rst)
begin
   if (rst)
   begin
      hi_r <= 16'h0000;
      lo_r <= 16'h0000;
   end
   else if (bus_wr && bus_addr == `PBPF_OFS_SEL_HIGH)
      hi_r <= bus_wdata;
   else if (bus_wr && bus_addr == `PBPF_OFS_SEL_LOW)
      lo_r <= bus_wdata;
end
////////////////////////////////////////
default clocking @(posedge mclk); endclocking
default disable iff (rst);
chk_rd_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
   else $error("read data not idle");
chk_rd_value: assert property (bus_rd |=> bus_rdata ==
   ($past(bus_addr) == `PBPF_OFS_SEL_HIGH ? $past(hi_r) :
   $past(bus_addr) == `PBPF_OFS_SEL_LOW ? $past(lo_r) : 16'h0000))
   else $error("read data wrong");
chk_gpio_route: assert property (lo_r[1:0] == 2'b00 |->
   pin_oe[0] == gpio_oe[0] && pin_out[0] == gpio_out[0])
   else $error("gpio route wrong");
chk_tp_drive: assert property (hi_r[15:14] == 2'b11 |->
   pin_oe[15] && pin_out[15] == timing_pattern[15])
   else $error("pattern route wrong");
chk_irq_idle: assert property (hi_r[15:14] != 2'b01 |-> ext_interrupt_7)
   else $error("interrupt not idle");
chk_txd_drive: assert property (hi_r[7:6] == 2'b10 |->
   pin_oe[11] && pin_out[11] == serial1_transmit)
   else $error("transmit route wrong");
chk_cmp_drive: assert property (lo_r[15:14] == 2'b10 |->
   pin_oe[7] && pin_out[7] == timer4_compare_out_b)
   else $error("compare route wrong");
chk_resv_release: assert property (lo_r[9:8] == 2'b01 |-> !pin_oe[4])
   else $error("reserved pin driven");
chk_wr_effect: assert property (bus_wr && bus_addr == `PBPF_OFS_SEL_LOW &&
   bus_wdata[9:8] == 2'b11 |=> pin_oe[4] && pin_out[4] == timing_pattern[4])
   else $error("selection late");
endmodule
bind pbpf_pin_mux pbpf_pin_mux_properties u_pbpf_pin_mux_properties (.*);

// File: pbpf_sync3.v
`timescale 1ns/10ps
`include "pbpf_defs.vh"

module pbpf_sync3
#(
   parameter RST_VAL = `PBPF_SYNC_RST
)
(
   input wire mclk,
   input wire rst,
   input wire async_in,
   output reg sync_out
);

reg s1_r;
reg s2_r;
reg s3_r;

// s1_r feeds s2_r only; the agreement check looks at the settled stages
always @(posedge mclk or posedge rst)
begin
   if (rst)
   begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      sync_out <= RST_VAL;
   end
   else
   begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
      begin
         sync_out <= s3_r;
      end
   end
end

endmodule
